// ### hdl/flash_pkg.sv
// Purpose: shared constants for the serial flash link and both of its ends
// Assumes: 25 MHz core clock on both ends
// Notes:   timing figures are held in their own units and converted here
package flash_pkg;

  // ------------------------------------------------------------------
  // clock and timing
  // ------------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 25000000;
  localparam int unsigned CLK_MHZ       = 25;
  localparam real         CHIP_ERASE_S  = 3.5;
  localparam int unsigned SECT_ERASE_MS = 1000;
  localparam int unsigned PROG_US       = 100;
  localparam int unsigned SRW_US        = 100;
  localparam int unsigned CHIP_ERASE_CYC = $rtoi(CHIP_ERASE_S * CLK_HZ);
  localparam int unsigned SECT_ERASE_CYC = SECT_ERASE_MS * (CLK_HZ / 1000);
  localparam int unsigned PROG_CYC      = PROG_US * CLK_MHZ;
  localparam int unsigned SRW_CYC       = SRW_US * CLK_MHZ;
  localparam logic [1:0]  HALF_LAST     = 2'h3;

  // ------------------------------------------------------------------
  // opcodes, bit 3 is don't-care
  // ------------------------------------------------------------------
  localparam logic [7:0] OP_MASK  = 8'hf7;
  localparam logic [7:0] OP_SET_WL = 8'h06;
  localparam logic [7:0] OP_WRDI   = 8'h04;
  localparam logic [7:0] OP_ST_RD  = 8'h05;
  localparam logic [7:0] OP_ST_WR  = 8'h01;
  localparam logic [7:0] OP_READ  = 8'h03;
  localparam logic [7:0] OP_PROG  = 8'h02;
  localparam logic [7:0] OP_SERA  = 8'h52;
  localparam logic [7:0] OP_CERA  = 8'h62;

  // ------------------------------------------------------------------
  // array geometry and serial framing
  // ------------------------------------------------------------------
  localparam int         ADDR_W    = 17;
  localparam int         PAGE_LSB  = 8;
  localparam int         SECT_LSB  = 15;
  localparam int         BYTE_W    = 8;
  localparam int         MEM_SIZE  = 1 << ADDR_W;
  localparam logic [2:0] BIT_LAST  = 3'h7;
  localparam logic [1:0] ADDR_LAST = 2'h2;
  localparam logic [7:0] ERASED    = 8'hff;
  localparam logic [1:0] TOP_SECT  = 2'h3;

  // ------------------------------------------------------------------
  // status byte layout and protect levels
  // ------------------------------------------------------------------
  localparam int         SR_WEL    = 1;
  localparam int         SR_BP_LSB = 2;
  localparam int         SR_PROT_EN = 7;
  localparam logic [7:0] SR_BUSY   = 8'hff;
  localparam logic [1:0] PL_NONE   = 2'h0;
  localparam logic [1:0] PL_QUART  = 2'h1;
  localparam logic [1:0] PL_HALF   = 2'h2;

  // ------------------------------------------------------------------
  // host register map
  // ------------------------------------------------------------------
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_RXDATA = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam logic [3:0] REG_PINS   = 4'hc;
  localparam int         CTRL_LAST  = 8;

  function automatic logic is_locked(input logic [ADDR_W-1:0] a,
                                     input logic [1:0] lvl);
    case (lvl)
      PL_NONE:  return 1'b0;
      PL_QUART: return a[ADDR_W-1 -: 2] == TOP_SECT;
      PL_HALF:  return a[ADDR_W-1];
      default:  return 1'b1;
    endcase
  endfunction : is_locked

  function automatic logic [7:0] make_status(input logic busy,
      input logic hw_protect_enable_bit, input logic [1:0] bp,
      input logic wel);
    logic [7:0] s;
    s = 8'h00;
    s[SR_WEL] = wel;
    s[SR_BP_LSB +: 2] = bp;
    s[SR_PROT_EN] = hw_protect_enable_bit;
    return busy ? SR_BUSY : s;
  endfunction : make_status

endpackage : flash_pkg

// ### hdl/spi_link_if.sv
// Purpose: serial link between flash controller and flash device
// Assumes: serial output idles high when not driven (pull-up)
// Notes:   enables are active low
`timescale 1ns/1ps
`default_nettype none
interface spi_link_if;
  logic cs_n;
  logic sck;
  logic si;
  logic wp_n;
  logic so;
  logic so_oe_n;
  logic so_line;

  // resolved serial output line, pulled high when released
  assign so_line = so_oe_n ? 1'b1 : so;

  modport flash (input cs_n, sck, si, wp_n, output so, so_oe_n);
  modport ctrl  (output cs_n, sck, si, wp_n, input so_line);
endinterface : spi_link_if
`default_nettype wire

// ### hdl/spi_flash_dev.sv
// Purpose: command execution of a small serial flash (device end)
// Assumes: link pins are asynchronous and sampled by the core clock
// Notes:   serial clock must stay at least 3 core cycles per phase
//
// Functional notes
// - no clearing protect enable while pin protects
// - status write needs latch and no hw protect
// - read: opcode, address, then data MSB first
// - read address auto-increments and wraps to zero
// - only address bits 16..0 are used
// - without latch, program/erase ignored until deselect
// - never program inside the locked range
// - program cycle starts only at deselect
// - host deselects in clock low after D0
// - while busy only status read is accepted
// - status bit 0 high while cycle runs
// - program 1..256 bytes, wrapping inside page
// - unsent bytes kept, later bytes overwrite earlier
// - host erases sector before reprogramming byte
// - latch clears when program/erase cycle ends
// - sector erase of unlocked 32K sector
// - chip erase of all unlocked sectors, 3.5 s
// - opcode decode with bit 3 don't care
// - protect level locks none, quarter, half, all
// - status byte layout, all ones when busy
`timescale 1ns/1ps
`default_nettype none
module spi_flash_dev #(
  parameter int unsigned PROG_CYC   = flash_pkg::PROG_CYC,
  parameter int unsigned SRW_CYC    = flash_pkg::SRW_CYC,
  parameter int unsigned SERASE_CYC = flash_pkg::SECT_ERASE_CYC,
  parameter int unsigned CERASE_CYC = flash_pkg::CHIP_ERASE_CYC
) (
  // clock and reset
  input  wire logic  i_core_clk,
  input  wire logic  i_reset_n,
  // serial link
  spi_link_if.flash  link,
  // status view
  output logic [7:0] o_status,
  output logic       o_busy
);

  typedef enum logic [2:0] {
    ST_CMD    = 3'b000,
    ST_ADDR   = 3'b001,
    ST_RDOUT  = 3'b010,
    ST_PROG   = 3'b011,
    ST_SRDATA = 3'b100,
    ST_ARMED  = 3'b101,
    ST_IGNORE = 3'b110
  } dev_state_t;

  typedef enum logic [3:0] {
    C_NONE = 4'b0000,
    C_READ = 4'b0001,
    C_PROG = 4'b0010,
    C_SE   = 4'b0011,
    C_CE   = 4'b0100,
    C_SET_WL = 4'b0101,
    C_WRDI   = 4'b0110,
    C_ST_RD  = 4'b0111,
    C_ST_WR  = 4'b1000
  } cmd_t;

  typedef enum logic [1:0] {
    J_PROG  = 2'b00,
    J_ERASE = 2'b01,
    J_SRW   = 2'b10
  } job_t;

  localparam int AW = flash_pkg::ADDR_W;
  localparam int PL = flash_pkg::PAGE_LSB;
  localparam int SL = flash_pkg::SECT_LSB;

  // ------------------------------------------------------------------
  // pin synchronisers and edge detection
  // ------------------------------------------------------------------
  logic [1:0] cs_q;
  logic [1:0] sck_q;
  logic [1:0] si_q;
  logic [1:0] wp_q;
  logic       cs_d;
  logic       sck_d;

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cs_q  <= 2'h3;
      sck_q <= 2'h0;
      si_q  <= 2'h0;
      wp_q  <= 2'h3;
      cs_d  <= 1'b1;
      sck_d <= 1'b0;
    end else begin
      cs_q  <= {cs_q[0], link.cs_n};
      sck_q <= {sck_q[0], link.sck};
      si_q  <= {si_q[0], link.si};
      wp_q  <= {wp_q[0], link.wp_n};
      cs_d  <= cs_q[1];
      sck_d <= sck_q[1];
    end
  end

  wire cs_n    = cs_q[1];
  wire wp_n    = wp_q[1];
  wire rise    = sck_q[1] && !sck_d && !cs_n;
  wire fall    = !sck_q[1] && sck_d && !cs_n;
  wire cs_rise = cs_n && !cs_d;

  // ------------------------------------------------------------------
  // state and decode
  // ------------------------------------------------------------------
  dev_state_t          state;
  cmd_t                cmd;
  logic [2:0]          bit_cnt;
  logic [1:0]          addr_cnt;
  logic [2:0]          out_cnt;
  logic [7:0]          in_sh;
  logic [7:0]          out_sh;
  logic [AW-1:0]       addr;
  logic [PL-1:0]       col;
  logic [255:0]        page_vld;
  logic [7:0]          page_buf [0:255];
  logic [7:0]          mem [0:flash_pkg::MEM_SIZE-1];
  logic                got;
  logic [7:0]          sr_new;
  logic                so;
  logic                busy;
  logic                walking;
  logic                wel;
  logic                hw_protect_enable_bit;
  logic [1:0]          bp;
  job_t                job;
  logic [31:0]         timer;
  logic [AW-1:0]       walk;
  logic [AW-1:0]       walk_end;

  wire [7:0]    rx_byte   = {in_sh[6:0], si_q[1]};
  wire          byte_done = rise && (bit_cnt == flash_pkg::BIT_LAST);
  wire [7:0]    op_m      = rx_byte & flash_pkg::OP_MASK;
  wire [AW-1:0] addr_in   = {addr[AW-9:0], rx_byte};
  wire [7:0]    rd_byte   = mem[(state == ST_ADDR) ? addr_in : addr + 17'h1];
  wire [7:0]    status_byte = flash_pkg::make_status(busy,
    hw_protect_enable_bit, bp, wel);

  wire cmd_t cmd_code =
      (op_m == flash_pkg::OP_READ) ? C_READ :
      (op_m == flash_pkg::OP_PROG) ? C_PROG :
      (op_m == flash_pkg::OP_SERA) ? C_SE   :
      (op_m == flash_pkg::OP_CERA) ? C_CE   :
      (op_m == flash_pkg::OP_SET_WL) ? C_SET_WL :
      (op_m == flash_pkg::OP_WRDI)   ? C_WRDI   :
      (op_m == flash_pkg::OP_ST_RD)  ? C_ST_RD  :
      (op_m == flash_pkg::OP_ST_WR)  ? C_ST_WR  : C_NONE;

  wire needs_wel = (cmd_code == C_PROG) || (cmd_code == C_SE) ||
                   (cmd_code == C_CE) || (cmd_code == C_ST_WR);
  wire busy_block = busy && (cmd_code != C_ST_RD);

  wire dev_state_t cmd_next =
      busy_block                ? ST_IGNORE :
      (cmd_code == C_ST_RD)     ? ST_RDOUT  :
      (cmd_code == C_READ)      ? ST_ADDR   :
      (needs_wel && !wel)       ? ST_IGNORE :
      (cmd_code == C_CE)        ? ST_ARMED  :
      (cmd_code == C_ST_WR)     ? ST_SRDATA :
      needs_wel                 ? ST_ADDR   : ST_IGNORE;

  wire dev_state_t after_addr =
      (cmd == C_READ) ? ST_RDOUT :
      (cmd == C_PROG) ? ST_PROG  : ST_ARMED;

  // ------------------------------------------------------------------
  // commit at deselect
  // ------------------------------------------------------------------
  // state and bit count still hold the frame's last values here
  wire commit  = cs_rise && (bit_cnt == 3'h0) && !busy;
  wire locked  = flash_pkg::is_locked(addr, bp);
  wire sr_ok   = wel && (!hw_protect_enable_bit || wp_n);
  wire go_prog = commit && (state == ST_PROG) && got && !locked;
  wire go_se   = commit && (state == ST_ARMED) && (cmd == C_SE) &&
                 !locked;
  wire go_ce   = commit && (state == ST_ARMED) && (cmd == C_CE);
  wire go_srw  = commit && (state == ST_SRDATA) && got && sr_ok;
  wire go_any  = go_prog || go_se || go_ce || go_srw;
  wire set_wel = commit && (state == ST_IGNORE) && (cmd == C_SET_WL);
  wire clr_wel = commit && (state == ST_IGNORE) && (cmd == C_WRDI);

  wire [AW-1:0] walk_start =
      go_prog ? {addr[AW-1:PL], {PL{1'b0}}} :
      go_se   ? {addr[AW-1:SL], {SL{1'b0}}} : '0;
  wire [AW-1:0] walk_stop =
      go_prog ? {addr[AW-1:PL], {PL{1'b1}}} :
      go_se   ? {addr[AW-1:SL], {SL{1'b1}}} : '1;
  wire [31:0] job_cyc =
      go_prog ? PROG_CYC : go_se ? SERASE_CYC : go_ce ? CERASE_CYC : SRW_CYC;
  wire job_t job_sel = go_prog ? J_PROG : go_srw ? J_SRW : J_ERASE;

  // ------------------------------------------------------------------
  // serial protocol
  // ------------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state    <= ST_CMD;
      cmd      <= C_NONE;
      bit_cnt  <= 3'h0;
      addr_cnt <= 2'h0;
      out_cnt  <= 3'h0;
      in_sh    <= 8'h00;
      out_sh   <= 8'h00;
      addr     <= '0;
      col      <= '0;
      page_vld <= '0;
      got      <= 1'b0;
      sr_new   <= 8'h00;
      so       <= 1'b0;
    end else if (cs_n) begin
      // idle high, so a busy status stream never opens on a stale bit
      so       <= 1'b1;
      state    <= ST_CMD;
      bit_cnt  <= 3'h0;
      addr_cnt <= 2'h0;
      out_cnt  <= 3'h0;
    end else begin
      if (rise) begin
        bit_cnt <= bit_cnt + 3'h1;
        in_sh   <= rx_byte;
      end
      if (byte_done) begin
        case (state)
          ST_CMD: begin
            state <= cmd_next;
            cmd   <= busy_block ? C_NONE : cmd_code;
            got   <= 1'b0;
            out_sh <= status_byte;
          end
          ST_ADDR: begin
            addr     <= addr_in;
            addr_cnt <= addr_cnt + 2'h1;
            col      <= addr_in[PL-1:0];
            if (addr_cnt == flash_pkg::ADDR_LAST) begin
              state    <= after_addr;
              page_vld <= '0;
              out_sh   <= rd_byte;
            end
          end
          ST_PROG: begin
            page_vld[col] <= 1'b1;
            col <= col + 8'h01;
            got <= 1'b1;
          end
          ST_SRDATA: begin
            sr_new <= rx_byte;
            got    <= 1'b1;
          end
          default: begin
          end
        endcase
      end
      // serial input is not looked at while streaming out
      if (fall && (state == ST_RDOUT)) begin
        so      <= out_sh[7];
        out_sh  <= {out_sh[6:0], 1'b0};
        out_cnt <= out_cnt + 3'h1;
        if (out_cnt == flash_pkg::BIT_LAST) begin
          out_sh <= (cmd == C_READ) ? rd_byte : status_byte;
          if (cmd == C_READ) begin
            addr <= addr + 17'h1;
          end
        end
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (byte_done && (state == ST_PROG)) begin
      page_buf[col] <= rx_byte;
    end
  end

  // ------------------------------------------------------------------
  // self-timed engine
  // ------------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      busy     <= 1'b0;
      walking  <= 1'b0;
      job      <= J_PROG;
      timer    <= 32'h0;
      walk     <= '0;
      walk_end <= '0;
      wel      <= 1'b0;
      hw_protect_enable_bit <= 1'b0;
      bp       <= flash_pkg::PL_NONE;
      o_status <= 8'h00;
    end else begin
      o_status <= status_byte;
      if (go_any) begin
        busy     <= 1'b1;
        walking  <= !go_srw;
        job      <= job_sel;
        timer    <= job_cyc;
        walk     <= walk_start;
        walk_end <= walk_stop;
      end else if (busy) begin
        if (timer != 32'h0) begin
          timer <= timer - 32'h1;
        end
        if (walking) begin
          walk <= walk + 17'h1;
          walking <= (walk != walk_end);
        end
        if ((timer == 32'h0) && !walking) begin
          busy <= 1'b0;
          wel  <= 1'b0;
          if (job == J_SRW) begin
            hw_protect_enable_bit <= sr_new[flash_pkg::SR_PROT_EN];
            bp <= sr_new[flash_pkg::SR_BP_LSB +: 2];
          end
        end
      end
      // never in the same cycle as the end-of-cycle clear
      if (set_wel) begin
        wel <= 1'b1;
      end else if (clr_wel) begin
        wel <= 1'b0;
      end
    end
  end

  // cells only lose bits when programmed; an erase is needed to restore
  always_ff @(posedge i_core_clk) begin
    if (busy && walking) begin
      if ((job == J_PROG) && page_vld[walk[PL-1:0]]) begin
        mem[walk] <= mem[walk] & page_buf[walk[PL-1:0]];
      end else if ((job == J_ERASE) &&
                   !flash_pkg::is_locked(walk, bp)) begin
        mem[walk] <= flash_pkg::ERASED;
      end
    end
  end

  assign link.so      = so;
  assign link.so_oe_n = link.cs_n || cs_n || (state != ST_RDOUT);
  assign o_busy       = busy;

endmodule : spi_flash_dev
`default_nettype wire

// ### hdl/spi_flash_ctl.sv
// Purpose: host-side serial controller, one byte per software request
// Assumes: software builds opcode, address and data byte by byte
// Notes:   serial clock mode 0, half period of four core cycles
`timescale 1ns/1ps
`default_nettype none
module spi_flash_ctl (
  // clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_reset_n,
  // register port
  input  wire logic [3:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  // serial link
  spi_link_if.ctrl         link
);

  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_LEAD = 3'b001,
    H_LOW  = 3'b010,
    H_HIGH = 3'b011,
    H_TAIL = 3'b100,
    H_GAP  = 3'b101
  } host_state_t;

  localparam int BW = flash_pkg::BYTE_W;

  host_state_t hstate;
  logic [1:0]  div_cnt;
  logic [2:0]  bit_cnt;
  logic [7:0]  tx_sh;
  logic [7:0]  rx_sh;
  logic [7:0]  rx_data;
  logic        last;
  logic        cs_n;
  logic        sck;
  logic        si;
  logic        wp_n;
  logic [1:0]  so_q;

  // ------------------------------------------------------------------
  // register decode
  // ------------------------------------------------------------------
  wire idle    = (hstate == H_IDLE);
  wire tick    = (div_cnt == flash_pkg::HALF_LAST);
  wire ctrl_wr = i_wr && (i_addr == flash_pkg::REG_CTRL) && idle;
  wire pins_wr = i_wr && (i_addr == flash_pkg::REG_PINS);
  wire [31:0] rd_mux =
      (i_addr == flash_pkg::REG_RXDATA) ? {24'h0, rx_data} :
      (i_addr == flash_pkg::REG_STATUS) ? {30'h0, !cs_n, !idle} :
      (i_addr == flash_pkg::REG_PINS)   ? {31'h0, wp_n} : 32'h0;
  wire [7:0] rx_next = {rx_sh[6:0], so_q[1]};

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rdata <= 32'h0;
      wp_n    <= 1'b1;
      so_q    <= 2'h3;
    end else begin
      o_rdata <= i_rd ? rd_mux : 32'h0;
      so_q    <= {so_q[0], link.so_line};
      if (pins_wr) begin
        wp_n <= i_wdata[0];
      end
    end
  end

  // ------------------------------------------------------------------
  // half-period divider
  // ------------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      div_cnt <= 2'h0;
    end else begin
      div_cnt <= (idle || tick) ? 2'h0 : div_cnt + 2'h1;
    end
  end

  // ------------------------------------------------------------------
  // byte shifter
  // ------------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      hstate  <= H_IDLE;
      bit_cnt <= 3'h0;
      tx_sh   <= 8'h00;
      rx_sh   <= 8'h00;
      rx_data <= 8'h00;
      last    <= 1'b0;
      cs_n    <= 1'b1;
      sck     <= 1'b0;
      si      <= 1'b0;
    end else begin
      case (hstate)
        H_IDLE: begin
          if (ctrl_wr) begin
            tx_sh   <= i_wdata[BW-1:0];
            last    <= i_wdata[flash_pkg::CTRL_LAST];
            bit_cnt <= 3'h0;
            cs_n    <= 1'b0;
            si      <= i_wdata[BW-1];
            hstate  <= cs_n ? H_LEAD : H_LOW;
          end
        end
        H_LEAD: begin
          if (tick) begin
            hstate <= H_LOW;
          end
        end
        H_LOW: begin
          if (tick) begin
            sck    <= 1'b1;
            hstate <= H_HIGH;
          end
        end
        H_HIGH: begin
          if (tick) begin
            sck     <= 1'b0;
            rx_sh   <= rx_next;
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == flash_pkg::BIT_LAST) begin
              rx_data <= rx_next;
              hstate  <= last ? H_TAIL : H_IDLE;
            end else begin
              si     <= tx_sh[6];
              tx_sh  <= {tx_sh[6:0], 1'b0};
              hstate <= H_LOW;
            end
          end
        end
        H_TAIL: begin
          if (tick) begin
            cs_n   <= 1'b1;
            hstate <= H_GAP;
          end
        end
        default: begin
          if (tick) begin
            hstate <= H_IDLE;
          end
        end
      endcase
    end
  end

  assign link.cs_n = cs_n;
  assign link.sck  = sck;
  assign link.si   = si;
  assign link.wp_n = wp_n;

endmodule : spi_flash_ctl
`default_nettype wire

// ### verif/spi_flash_chk.sv
// Purpose: link and status checks beside the flash link
// Assumes: inputs mirror link signals and device status view
// Notes:   status view lags busy by one cycle
`timescale 1ns/1ps
`default_nettype none
module spi_flash_chk (
  // clock and reset
  input wire logic       i_core_clk,
  input wire logic       i_reset_n,
  // link
  input wire logic       cs_n,
  input wire logic       sck,
  input wire logic       wp_n,
  input wire logic       so_oe_n,
  input wire logic       so_line,
  // device status
  input wire logic [7:0] o_status,
  input wire logic       o_busy
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);
  property p_so_off; cs_n |-> so_oe_n && so_line; endproperty
  a_so_off: assert property (p_so_off)
    else $error("so not released");
  property p_sck_idle; cs_n && $past(cs_n) |-> !sck; endproperty
  a_sck_idle: assert property (p_sck_idle)
    else $error("sck moved while deselected");
  property p_busy_ones; o_busy && $past(o_busy) |-> o_status == 8'hff;
  endproperty
  a_busy_ones: assert property (p_busy_ones)
    else $error("status not all ones while busy");
  property p_ready; !o_busy && !$past(o_busy)
    |-> o_status[0] == 1'b0 && o_status[6:4] == 3'h0; endproperty
  a_ready: assert property (p_ready)
    else $error("ready status wrong");
  property p_start; $rose(o_busy) |-> cs_n && $past(cs_n); endproperty
  a_start: assert property (p_start)
    else $error("cycle began while selected");
  property p_latch_need; $rose(o_busy) |-> o_status[1]; endproperty
  a_latch_need: assert property (p_latch_need)
    else $error("cycle began without latch");
  property p_latch_clr; $fell(o_busy) |-> ##2 !o_status[1]; endproperty
  a_latch_clr: assert property (p_latch_clr)
    else $error("latch kept after cycle");
  property p_hw_protect_enable_bit_kept; !wp_n && o_status[7] && !o_status[0]
    |=> o_status[7]; endproperty
  a_hw_protect_enable_bit_kept: assert property (p_hw_protect_enable_bit_kept)
    else $error("protect enable cleared under pin");
  property p_busy_quiet; o_busy && $past(o_busy, 4) && !so_oe_n
    |-> so_line; endproperty
  a_busy_quiet: assert property (p_busy_quiet)
    else $error("data out while busy");
endmodule : spi_flash_chk
`default_nettype wire

// ### verif/test_serial_flash_read_program_erase.sv
// Purpose: end-to-end bench, controller driving the flash device
// Assumes: short self-timed counts keep the run brief
// Notes:   bytes never erased are not compared, array has no reset
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
  err_count++; $display("BAD %s exp %h got %h", n, e, g); end end
module test_serial_flash_read_program_erase;
  logic        i_core_clk;
  logic        i_reset_n;
  logic [3:0]  i_addr;
  logic [31:0] i_wdata;
  logic        i_wr;
  logic        i_rd;
  logic [31:0] o_rdata;
  logic [7:0]  o_status;
  logic        o_busy;
  logic [7:0]  mem[int];
  logic [7:0]  pg[int];
  logic [7:0]  rx;
  logic [31:0] lfsr;
  int          err_count;
  int          tests_run;
  spi_link_if link ();
  spi_flash_dev #(.PROG_CYC(10), .SRW_CYC(10), .SERASE_CYC(10),
    .CERASE_CYC(10)) spi_flash_dev_inst (.i_core_clk(i_core_clk),
    .i_reset_n(i_reset_n), .link(link.flash), .o_status(o_status),
    .o_busy(o_busy));
  spi_flash_ctl spi_flash_ctl_inst (.i_core_clk(i_core_clk),
    .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .link(link.ctrl));
  spi_flash_chk chk (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
    .cs_n(link.cs_n), .sck(link.sck), .wp_n(link.wp_n),
    .so_oe_n(link.so_oe_n), .so_line(link.so_line),
    .o_status(o_status), .o_busy(o_busy));
  // ----------------------------------------------------------------
  // bus and link tasks
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    @(posedge i_core_clk);
    d = o_rdata[7:0];
  endtask : reg_rd
  task automatic idle_wait();
    logic [7:0] s;
    s = 8'h01;
    for (int n = 0; n < 200 && s[0]; n++) reg_rd(flash_pkg::REG_STATUS, s);
    `CHK("ctl idle", 1'b0, s[0])
    if (s[0]) wrap_up();
  endtask : idle_wait
  // one byte on the link, reply is what came back during it
  task automatic xfer(input logic [7:0] b, input logic last,
                      output logic [7:0] r);
    idle_wait();
    reg_wr(flash_pkg::REG_CTRL, {23'h0, last, b});
    idle_wait();
    reg_rd(flash_pkg::REG_RXDATA, r);
  endtask : xfer
  task automatic frame(input logic [7:0] q[$], input logic last,
                       output logic [7:0] r);
    foreach (q[k]) xfer(q[k], last && k == q.size() - 1, r);
  endtask : frame
  task automatic rd_status(output logic [7:0] s);
    frame({8'h05, 8'h00}, 1'b1, s);
  endtask : rd_status
  task automatic dev_wait();
    logic [7:0] s;
    s = 8'hff;
    for (int n = 0; n < 1000 && s[0]; n++) begin
      rd_status(s);
      if (s[0]) `CHK("busy status", 8'hff, s)
    end
    `CHK("device done", 1'b0, s[0])
    if (s[0]) wrap_up();
  endtask : dev_wait
  // ----------------------------------------------------------------
  // stimulus
  // ----------------------------------------------------------------
  initial begin
    i_core_clk = 1'b0;
    forever #20 i_core_clk = ~i_core_clk;
  end
  initial begin
    i_reset_n = 1'b0;
    {i_addr, i_wdata, i_wr, i_rd} = '0;
    {err_count, tests_run} = '0;
    lfsr = 32'h7954c307;
    repeat (4) @(posedge i_core_clk);
    i_reset_n <= 1'b1;
    repeat (4) @(posedge i_core_clk);
    rd_status(rx);
    `CHK("reset status", 8'h00, rx)
    reg_rd(4'h2, rx);
    `CHK("unmapped", 8'h00, rx)
    frame({8'h62}, 1'b1, rx);
    rd_status(rx);
    `CHK("no latch", 8'h00, rx)
    $display("test reset and latch done");
    frame({8'h06}, 1'b1, rx);
    rd_status(rx);
    `CHK("latch set", 8'h02, rx)
    frame({8'h5a, 8'hfe, 8'h00, 8'h10}, 1'b1, rx);
    frame({8'h06}, 1'b1, rx);
    dev_wait();
    rd_status(rx);
    `CHK("erase end", 8'h00, rx)
    for (int k = 0; k < 32768; k++) mem[k] = 8'hff;
    $display("test sector erase done");
    frame({8'h06}, 1'b1, rx);
    frame({8'h0a, 8'h00, 8'h00, 8'hfe}, 1'b0, rx);
    for (int k = 0; k < 258; k++) begin
      lfsr = lfsr_next(lfsr);
      pg[(254 + k) % 256] = lfsr[7:0];
      xfer(lfsr[7:0], k == 257, rx);
    end
    foreach (pg[k]) mem[k] = mem[k] & pg[k];
    dev_wait();
    $display("test page program done");
    // top byte was never erased, its value is skipped
    frame({8'h03, 8'h01, 8'hff, 8'hff, lfsr[7:0]}, 1'b0, rx);
    for (int k = 0; k < 260; k++) begin
      xfer(lfsr[15:8], k == 259, rx);
      `CHK("read byte", mem[k], rx)
    end
    $display("test wrapped read done");
    frame({8'h06}, 1'b1, rx);
    frame({8'h01, 8'h84}, 1'b1, rx);
    dev_wait();
    rd_status(rx);
    `CHK("status write", 8'h84, rx)
    reg_wr(flash_pkg::REG_PINS, 32'h0);
    frame({8'h06}, 1'b1, rx);
    frame({8'h01, 8'h00}, 1'b1, rx);
    dev_wait();
    rd_status(rx);
    `CHK("enable kept", 8'h84, rx & 8'hfd)
    frame({8'h06}, 1'b1, rx);
    frame({8'h02, 8'h01, 8'h80, 8'h00, 8'h00}, 1'b1, rx);
    rd_status(rx);
    `CHK("locked program", 8'h86, rx)
    $display("test protection done");
    wrap_up();
  end
endmodule : test_serial_flash_read_program_erase
`default_nettype wire
